//--- design/fsl_pkg.sv
// constants shared by the flash protection/status host controller and its bus-cycle engine
// assumes one 40 MHz clock; flash pins are sampled synchronously to it
// How it works
// - status mode held until next command
// - bits 4 to 2 reserved, ignored
// - signature: command 90h then address 00h
// - write protect held low through power transitions; here held low only from reset until software sets CFG_WP
// - unlock: setup, start, confirm, end order
// - block address three or two cycles
// - start block not above end block
package fsl_pkg;
  // strobe timing
  localparam int CLK_MHZ = 40;
  localparam int STROBE_NS = 50;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] STROBE_LAST = STROBE_CYC - 4'h1;
  // flash command codes and signature address
  localparam logic [7:0] CMD_SIG = 8'h90;
  localparam logic [7:0] ADDR_SIG = 8'h00;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_LOCK_ALL = 8'h2A;
  localparam logic [7:0] CMD_UNLOCK_SETUP = 8'h23;
  localparam logic [7:0] CMD_UNLOCK_CONF = 8'h24;
  // bus cycle kinds
  localparam logic [1:0] K_CMD = 2'h0;
  localparam logic [1:0] K_ADDR = 2'h1;
  localparam logic [1:0] K_READ = 2'h2;
  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CFG = 5'h04;
  localparam logic [4:0] REG_START = 5'h08;
  localparam logic [4:0] REG_END = 5'h0C;
  localparam logic [4:0] REG_STAT = 5'h10;
  localparam logic [4:0] REG_SIG = 5'h14;
  // operation codes in the control register
  localparam logic [2:0] OP_STATUS = 3'h1;
  localparam logic [2:0] OP_POLL = 3'h2;
  localparam logic [2:0] OP_SIG = 3'h3;
  localparam logic [2:0] OP_LOCK = 3'h4;
  localparam logic [2:0] OP_UNLOCK = 3'h5;
  // config bits
  localparam int CFG_WP = 0;
  localparam int CFG_LOCKEN = 1;
  localparam int CFG_LARGE = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  // flash status byte
  localparam int SB_READY = 6;
  localparam logic [7:0] RSV_MASK = 8'hE3;
  // last address cycle per block address, last signature read, block address width
  localparam logic [1:0] ADDR_LAST_LARGE = 2'h2;
  localparam logic [1:0] ADDR_LAST_SMALL = 2'h1;
  localparam logic [2:0] SIG_LAST = 3'h3;
  localparam int BLK_W = 24;
endpackage

//--- design/fsl_bus_cycle.sv
// one flash bus cycle: command latch, address latch or read, with fixed strobe timing unless hold stretches a read
// assumes the caller holds start, kind and data steady until done
`timescale 1ns/100ps
`default_nettype none
module fsl_bus_cycle (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic start, // request a cycle
  input wire logic [1:0] kind, // cycle kind
  input wire logic [7:0] data, // command or address byte
  input wire logic hold, // keep read strobe low and resample
  output logic done, // cycle complete
  output logic rdValid, // read byte captured
  output logic [7:0] rdData, // captured byte
  output logic cle, // command latch enable
  output logic ale, // address latch enable
  output logic weN, // write strobe, active low
  output logic reN, // read strobe, active low
  input wire logic [7:0] ioIn, // data lines in
  output logic [7:0] ioOut, // data lines out
  output logic ioOeN // data output enable, low drives
);
  typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH} fsl_eng_e;
  fsl_eng_e st;
  logic [3:0] cntReg;
  logic [1:0] kindReg;
  logic isRead;
  logic lowEnd;

  assign isRead = kindReg == fsl_pkg::K_READ;
  assign lowEnd = st == E_LOW && cntReg == 4'h0;
  assign done = st == E_HIGH && cntReg == 4'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= E_IDLE;
      cntReg <= 4'h0;
    end else begin
      case (st)
        E_IDLE: begin
          if (start) begin
            st <= E_LOW;
            cntReg <= fsl_pkg::STROBE_LAST;
          end
        end
        E_LOW: begin
          if (cntReg != 4'h0) begin
            cntReg <= cntReg - 4'h1;
          end else if (!(isRead && hold)) begin
            st <= E_HIGH;
            cntReg <= fsl_pkg::STROBE_LAST;
          end
        end
        default: begin
          if (cntReg == 4'h0) begin
            st <= E_IDLE;
          end else begin
            cntReg <= cntReg - 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kindReg <= fsl_pkg::K_CMD;
      cle <= 1'b0;
      ale <= 1'b0;
      weN <= 1'b1;
      reN <= 1'b1;
      ioOut <= 8'h00;
      ioOeN <= 1'b1;
    end else if (st == E_IDLE && start) begin
      kindReg <= kind;
      cle <= kind == fsl_pkg::K_CMD;
      ale <= kind == fsl_pkg::K_ADDR;
      ioOut <= data;
      ioOeN <= kind == fsl_pkg::K_READ;
      weN <= kind == fsl_pkg::K_READ;
      reN <= kind != fsl_pkg::K_READ;
    end else if (lowEnd && !(isRead && hold)) begin
      weN <= 1'b1;
      reN <= 1'b1;
    end else if (done) begin
      cle <= 1'b0;
      ale <= 1'b0;
      ioOeN <= 1'b1;
    end
  end

  // sample after the access time; in hold every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      rdData <= 8'h00;
    end else begin
      rdValid <= lowEnd && isRead;
      if (lowEnd && isRead) begin
        rdData <= ioIn;
      end
    end
  end

  AST_WE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(weN) |-> !weN [*2] ##1 weN)
    else $error("write strobe pulse width wrong");

  AST_READ_SAMPLE: assert property (@(posedge clk) disable iff (!rst_n)
    rdValid |-> $past(reN) == 1'b0)
    else $error("read byte taken with read strobe high");

  AST_NO_DRIVE_ON_READ: assert property (@(posedge clk) disable iff (!rst_n)
    !reN |-> ioOeN && weN)
    else $error("data driven during read");
endmodule
`default_nettype wire

//--- design/fsl_host_ctrl.sv
// host controller for status, signature and block lock sequences of a flash device
// assumes an Avalon-MM master with waitrequest and pins synchronous to clk
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fsl_host_ctrl (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic [4:0] avAddress, // byte address
  input wire logic avRead, // read request
  input wire logic avWrite, // write request
  input wire logic [31:0] avWritedata, // write data
  output logic [31:0] avReaddata, // read data
  output logic avWaitrequest, // stall
  output logic ceN, // chip select, active low
  output logic cle, // command latch enable
  output logic ale, // address latch enable
  output logic weN, // write strobe, active low
  output logic reN, // read strobe, active low
  output logic wpN, // write protect, active low
  output logic lockFeatureEnable, // block lock enable
  input wire logic readyBusyN, // device ready, low busy
  input wire logic [7:0] ioIn, // data lines in
  output logic [7:0] ioOut, // data lines out
  output logic ioOeN // data output enable, low drives
);
  typedef enum logic [2:0] {
    S_IDLE, S_WAITRB, S_CMD, S_ADDR, S_CMD2, S_ADDR2, S_READ, S_DONE
  } fsl_state_e;
  fsl_state_e state;
  logic [2:0] cfgReg;
  logic [fsl_pkg::BLK_W-1:0] startBlkReg;
  logic [fsl_pkg::BLK_W-1:0] endBlkReg;
  logic [2:0] opReg;
  logic errReg;
  logic [7:0] statByteReg;
  logic [31:0] sigReg;
  logic ackReg;
  logic [31:0] rdDataReg;
  logic [1:0] addrIdxReg;
  logic [2:0] readIdxReg;
  logic ceNReg;
  logic busy;
  logic req;
  logic canAccept;
  logic wrTake;
  logic launch;
  logic lockOk;
  logic refuse;
  logic [1:0] addrLast;
  logic engStart;
  logic [1:0] engKind;
  logic [7:0] engData;
  logic engHold;
  logic engDone;
  logic engRdValid;
  logic [7:0] engRdData;
  logic [31:0] readMux;
  logic isStatOp;

  function automatic logic [7:0] addrByte(input logic [fsl_pkg::BLK_W-1:0] blk,
                                          input logic [1:0] idx);
    addrByte = blk[{idx, 3'b000} +: 8];
  endfunction

  function automatic logic [7:0] cmdFor(input logic [2:0] op);
    if (op == fsl_pkg::OP_SIG) begin
      cmdFor = fsl_pkg::CMD_SIG;
    end else if (op == fsl_pkg::OP_LOCK) begin
      cmdFor = fsl_pkg::CMD_LOCK_ALL;
    end else if (op == fsl_pkg::OP_UNLOCK) begin
      cmdFor = fsl_pkg::CMD_UNLOCK_SETUP;
    end else begin
      cmdFor = fsl_pkg::CMD_STATUS;
    end
  endfunction

  // register bus
  assign busy = state != S_IDLE;
  assign req = avRead || avWrite;
  assign canAccept = !(avWrite && avAddress == fsl_pkg::REG_CTRL && busy);
  assign avWaitrequest = req && !ackReg;
  assign wrTake = avWrite && ackReg;
  assign launch = wrTake && avAddress == fsl_pkg::REG_CTRL;
  assign avReaddata = rdDataReg;

  always_comb begin
    if (avAddress == fsl_pkg::REG_CTRL) begin
      readMux = {29'h0, opReg};
    end else if (avAddress == fsl_pkg::REG_CFG) begin
      readMux = {29'h0, cfgReg};
    end else if (avAddress == fsl_pkg::REG_START) begin
      readMux = {8'h00, startBlkReg};
    end else if (avAddress == fsl_pkg::REG_END) begin
      readMux = {8'h00, endBlkReg};
    end else if (avAddress == fsl_pkg::REG_STAT) begin
      readMux = {16'h0000, statByteReg, 5'h00, readyBusyN, errReg, busy};
    end else if (avAddress == fsl_pkg::REG_SIG) begin
      readMux = sigReg;
    end else begin
      readMux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ackReg <= 1'b0;
      rdDataReg <= 32'h0000_0000;
    end else begin
      ackReg <= req && !ackReg && canAccept;
      if (req && !ackReg) begin
        rdDataReg <= readMux;
      end
    end
  end

  // configuration; protect stays asserted from reset until software releases it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReg <= fsl_pkg::CFG_RESET;
      startBlkReg <= '0;
      endBlkReg <= '0;
    end else if (wrTake) begin
      if (avAddress == fsl_pkg::REG_CFG) begin
        cfgReg <= avWritedata[2:0];
      end else if (avAddress == fsl_pkg::REG_START) begin
        startBlkReg <= avWritedata[fsl_pkg::BLK_W-1:0];
      end else if (avAddress == fsl_pkg::REG_END) begin
        endBlkReg <= avWritedata[fsl_pkg::BLK_W-1:0];
      end
    end
  end

  assign wpN = cfgReg[fsl_pkg::CFG_WP];
  assign lockFeatureEnable = cfgReg[fsl_pkg::CFG_LOCKEN];

  // sequencing
  assign lockOk = cfgReg[fsl_pkg::CFG_LOCKEN];
  assign refuse = (avWritedata[2:0] == fsl_pkg::OP_LOCK && !lockOk) ||
                  (avWritedata[2:0] == fsl_pkg::OP_UNLOCK &&
                   (!lockOk || startBlkReg > endBlkReg)) ||
                  avWritedata[2:0] == 3'h0 || avWritedata[2:0] > fsl_pkg::OP_UNLOCK;
  assign addrLast = (opReg == fsl_pkg::OP_SIG) ? 2'h0 :
                    cfgReg[fsl_pkg::CFG_LARGE] ? fsl_pkg::ADDR_LAST_LARGE :
                    fsl_pkg::ADDR_LAST_SMALL;
  assign isStatOp = opReg == fsl_pkg::OP_STATUS || opReg == fsl_pkg::OP_POLL;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      opReg <= 3'h0;
      addrIdxReg <= 2'h0;
      readIdxReg <= 3'h0;
    end else begin
      case (state)
        S_IDLE: begin
          addrIdxReg <= 2'h0;
          readIdxReg <= 3'h0;
          if (launch && !refuse) begin
            opReg <= avWritedata[2:0];
            if (avWritedata[2:0] == fsl_pkg::OP_STATUS ||
                avWritedata[2:0] == fsl_pkg::OP_POLL) begin
              state <= S_CMD;
            end else begin
              state <= S_WAITRB;
            end
          end
        end
        S_WAITRB: begin
          if (readyBusyN) begin
            state <= S_CMD;
          end
        end
        S_CMD: begin
          if (engDone) begin
            if (isStatOp) begin
              state <= S_READ;
            end else if (opReg == fsl_pkg::OP_LOCK) begin
              state <= S_DONE;
            end else begin
              state <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          if (engDone) begin
            if (addrIdxReg == addrLast) begin
              addrIdxReg <= 2'h0;
              state <= (opReg == fsl_pkg::OP_UNLOCK) ? S_CMD2 : S_READ;
            end else begin
              addrIdxReg <= addrIdxReg + 2'h1;
            end
          end
        end
        S_CMD2: begin
          if (engDone) begin
            state <= S_ADDR2;
          end
        end
        S_ADDR2: begin
          if (engDone) begin
            if (addrIdxReg == addrLast) begin
              state <= S_DONE;
            end else begin
              addrIdxReg <= addrIdxReg + 2'h1;
            end
          end
        end
        S_READ: begin
          if (engDone) begin
            if (opReg == fsl_pkg::OP_SIG && readIdxReg != fsl_pkg::SIG_LAST) begin
              readIdxReg <= readIdxReg + 3'h1;
            end else begin
              state <= S_DONE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // refused orders
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errReg <= 1'b0;
    end else if (launch) begin
      errReg <= refuse;
    end
  end

  // chip select low only during an active sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ceNReg <= 1'b1;
    end else begin
      ceNReg <= !(state == S_CMD || state == S_ADDR || state == S_CMD2 ||
                  state == S_ADDR2 || state == S_READ);
    end
  end
  assign ceN = ceNReg;

  // engine request
  // no stray cycle in the done slot, where chip select is still low
  assign engStart = !ceNReg && state != S_DONE;
  always_comb begin
    engKind = fsl_pkg::K_CMD;
    engData = cmdFor(opReg);
    if (state == S_CMD2) begin
      engData = fsl_pkg::CMD_UNLOCK_CONF;
    end else if (state == S_ADDR) begin
      engKind = fsl_pkg::K_ADDR;
      engData = (opReg == fsl_pkg::OP_SIG) ? fsl_pkg::ADDR_SIG :
                addrByte(startBlkReg, addrIdxReg);
    end else if (state == S_ADDR2) begin
      engKind = fsl_pkg::K_ADDR;
      engData = addrByte(endBlkReg, addrIdxReg);
    end else if (state == S_READ) begin
      engKind = fsl_pkg::K_READ;
    end
  end
  // poll keeps the read strobe low until the device reports ready
  assign engHold = state == S_READ && opReg == fsl_pkg::OP_POLL &&
                   !(engRdValid && engRdData[fsl_pkg::SB_READY]);

  // captured bytes; reserved status bits cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statByteReg <= 8'h00;
      sigReg <= 32'h0000_0000;
    end else if (engRdValid && state == S_READ) begin
      if (isStatOp) begin
        statByteReg <= engRdData & fsl_pkg::RSV_MASK;
      end else begin
        sigReg[{readIdxReg[1:0], 3'b000} +: 8] <= engRdData;
      end
    end
  end

  fsl_bus_cycle uCycle (
    .clk(clk),
    .rst_n(rst_n),
    .start(engStart),
    .kind(engKind),
    .data(engData),
    .hold(engHold),
    .done(engDone),
    .rdValid(engRdValid),
    .rdData(engRdData),
    .cle(cle),
    .ale(ale),
    .weN(weN),
    .reN(reN),
    .ioIn(ioIn),
    .ioOut(ioOut),
    .ioOeN(ioOeN)
  );

  AST_SIG_ADDR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_ADDR && opReg == fsl_pkg::OP_SIG |-> engData == fsl_pkg::ADDR_SIG)
    else $error("signature address byte not zero");

  AST_SIG_ONE_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_ADDR && opReg == fsl_pkg::OP_SIG && engDone |=> state == S_READ)
    else $error("signature sent more than one address cycle");

  AST_SIG_FOUR: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_READ && opReg == fsl_pkg::OP_SIG && engDone && readIdxReg == fsl_pkg::SIG_LAST
    |=> state == S_DONE)
    else $error("signature did not end after four reads");

  AST_UNLOCK_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_CMD2 |-> $past(state) == S_ADDR || $past(state) == S_CMD2)
    else $error("unlock confirm not after start address");

  AST_ADDR_CYCLES: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state == S_CMD2) |-> $past(addrIdxReg) ==
      (cfgReg[fsl_pkg::CFG_LARGE] ? fsl_pkg::ADDR_LAST_LARGE : fsl_pkg::ADDR_LAST_SMALL))
    else $error("wrong number of block address cycles");

  AST_RANGE_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_CMD && opReg == fsl_pkg::OP_UNLOCK |-> startBlkReg <= endBlkReg)
    else $error("unlock issued with start above end");

  AST_LOCK_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state == S_WAITRB) && (opReg == fsl_pkg::OP_LOCK || opReg == fsl_pkg::OP_UNLOCK)
    |-> lockFeatureEnable)
    else $error("lock command without lock enable");

  AST_WAIT_READY: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_WAITRB && !readyBusyN |=> state == S_WAITRB)
    else $error("command issued while device busy");

  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (statByteReg & ~fsl_pkg::RSV_MASK) == 8'h00)
    else $error("reserved status bits kept");

  AST_WP_FROM_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(wpN) |-> $past(wrTake) && $past(avAddress) == fsl_pkg::REG_CFG)
    else $error("write protect released without config write");
endmodule
`default_nettype wire

//--- verif/fsl_flash_model.sv
// behavioural flash device: status byte, signature words, block lock range
// assumes host pins change just after clk edges; write cycles latch on strobe rise
`timescale 1ns/100ps
`default_nettype none
module fsl_flash_model #(
  parameter logic [7:0] MAKER = 8'h00, // arbitrary
  parameter logic [7:0] DEVID = 8'h00, // arbitrary
  parameter logic [7:0] RSVW = 8'h00, // arbitrary
  parameter logic [7:0] CFGW = 8'h00 // arbitrary
) (
  input wire logic clk, // clock
  input wire logic ceN, // chip select
  input wire logic cle, // command latch
  input wire logic ale, // address latch
  input wire logic weN, // write strobe
  input wire logic reN, // read strobe
  input wire logic wpN, // write protect
  input wire logic lockFeatureEnable, // lock enable
  input wire logic [7:0] ioOut, // data from host
  input wire logic busy, // array engine busy
  input wire logic [1:0] fail, // previous page fail, operation fail
  input wire logic [1:0] cache, // cache programming active, cache register free
  input wire logic supplyLow, // supply below lockout threshold
  output logic readyBusyN, // ready line
  output logic [7:0] ioIn, // data to host
  output logic lockedAll, // every block locked
  output logic [23:0] rngStart, // unlocked range start
  output logic [23:0] rngEnd, // unlocked range end
  output logic [15:0] wrCount // write cycles seen
);
  logic weQ = 1'b1;
  logic reQ = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [1:0] sigIdx = 2'h0;
  logic sigAddr = 1'b0;
  logic endPhase = 1'b0;
  logic [1:0] aCnt = 2'h0;
  logic [7:0] lastByte = 8'h00;
  logic [7:0] stat;
  logic [7:0] word;
  logic [7:0] outByte;
  assign readyBusyN = !busy;
  assign stat = {wpN, cache[1] ? cache[0] : !busy, !busy,
      3'b101, fail};
  assign word = (sigIdx == 2'h0) ? MAKER : (sigIdx == 2'h1) ? DEVID
      : (sigIdx == 2'h2) ? RSVW : CFGW;
  assign outByte = (mode == 2'h1) ? stat : (mode == 2'h2 && sigAddr) ? word : ~lastByte;
  // released lines show the inverse of the last byte
  assign ioIn = (ceN == 1'b0 && reN == 1'b0) ? outByte : ~lastByte;
  initial begin
    lockedAll = 1'b1;
    rngStart = 24'h0;
    rngEnd = 24'h0;
    wrCount = 16'h0;
  end
  always @(posedge clk) begin
    weQ <= weN;
    reQ <= reN;
    if (ceN == 1'b0 && reN == 1'b0) lastByte <= ioIn;
    if (!ceN && reN && !reQ && mode == 2'h2) sigIdx <= sigIdx + 2'h1;
    if (!ceN && weN && !weQ && !supplyLow) begin
      wrCount <= wrCount + 16'h1;
      if (cle && (!busy || ioOut == fsl_pkg::CMD_STATUS)) begin
        aCnt <= 2'h0;
        mode <= 2'h0;
        case (ioOut)
          fsl_pkg::CMD_STATUS: mode <= 2'h1;
          fsl_pkg::CMD_SIG: begin
            mode <= 2'h2;
            sigIdx <= 2'h0;
            sigAddr <= 1'b0;
          end
          fsl_pkg::CMD_LOCK_ALL: if (lockFeatureEnable) lockedAll <= 1'b1;
          fsl_pkg::CMD_UNLOCK_SETUP: if (lockFeatureEnable) begin
            mode <= 2'h3;
            endPhase <= 1'b0;
            rngStart <= 24'h0;
            rngEnd <= 24'h0;
          end
          fsl_pkg::CMD_UNLOCK_CONF: if (lockFeatureEnable && mode == 2'h3) begin
            mode <= 2'h3;
            endPhase <= 1'b1;
            lockedAll <= 1'b0;
          end
          default: ;
        endcase
      end else if (ale && mode == 2'h2) begin
        sigAddr <= (ioOut == fsl_pkg::ADDR_SIG);
      end else if (ale && mode == 2'h3) begin
        if (endPhase) rngEnd[8 * aCnt +: 8] <= ioOut;
        else rngStart[8 * aCnt +: 8] <= ioOut;
        aCnt <= aCnt + 2'h1;
      end
    end
    if (!wpN) lockedAll <= 1'b1;
  end
endmodule
`default_nettype wire

//--- verif/fsl_host_ctrl_tb_top.sv
// self-checking bench for the flash status/signature/lock host controller
// assumes the behavioural flash model of fsl_flash_model.sv on the far side
`timescale 1ns/100ps
`default_nettype none
module fsl_host_ctrl_tb_top;
  localparam logic [7:0] MK = 8'h5C; // arbitrary
  localparam logic [7:0] DV = 8'h3E; // arbitrary
  localparam logic [7:0] RW = 8'h7B; // arbitrary
  localparam logic [7:0] CW = 8'h15; // arbitrary
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avAddress = 5'h00;
  logic avRead = 1'b0;
  logic avWrite = 1'b0;
  logic [31:0] avWritedata = 32'h0;
  logic [31:0] avReaddata;
  logic avWaitrequest, ceN, cle, ale, weN, reN, wpN, lockFeatureEnable, readyBusyN, ioOeN;
  logic [7:0] ioIn, ioOut;
  logic busy = 1'b0;
  logic [1:0] fail = 2'h0;
  logic [1:0] cache = 2'h0;
  logic supplyLow = 1'b0;
  logic lockedAll;
  logic [23:0] rngStart, rngEnd;
  logic [15:0] wrCount;
  logic [31:0] rd;
  int errors = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  fsl_host_ctrl dut_u (.clk(clk), .rst_n(rst_n), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWritedata(avWritedata), .avReaddata(avReaddata),
    .avWaitrequest(avWaitrequest), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN), .reN(reN),
    .wpN(wpN), .lockFeatureEnable(lockFeatureEnable), .readyBusyN(readyBusyN), .ioIn(ioIn),
    .ioOut(ioOut), .ioOeN(ioOeN));
  fsl_flash_model #(.MAKER(MK), .DEVID(DV), .RSVW(RW), .CFGW(CW)) flash_u (.clk(clk),
    .ceN(ceN), .cle(cle), .ale(ale), .weN(weN), .reN(reN), .wpN(wpN),
    .lockFeatureEnable(lockFeatureEnable), .ioOut(ioOut), .busy(busy), .fail(fail),
    .cache(cache), .supplyLow(supplyLow),
    .readyBusyN(readyBusyN), .ioIn(ioIn), .lockedAll(lockedAll), .rngStart(rngStart),
    .rngEnd(rngEnd), .wrCount(wrCount));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avAddress <= a;
    avWritedata <= d;
    avWrite <= wr;
    avRead <= !wr;
    @(posedge clk);
    while (avWaitrequest !== 1'b0) @(posedge clk);
    rd = avReaddata;
    avWrite <= 1'b0;
    avRead <= 1'b0;
  endtask
  task automatic idle();
    do begin
      bus(1'b0, fsl_pkg::REG_STAT, 32'h0);
    end while (rd[0] !== 1'b0);
  endtask
  task automatic op(input logic [2:0] o);
    bus(1'b1, fsl_pkg::REG_CTRL, {29'h0, o});
    idle();
  endtask
  task automatic t_reset();
    check("wpN", 32'h0, {31'h0, wpN});
    check("lock enable", 32'h0, {31'h0, lockFeatureEnable});
    check("locked", 32'h1, {31'h0, lockedAll});
    bus(1'b1, 5'h18, 32'hFFFFFFFF);
    bus(1'b0, 5'h18, 32'h0);
    check("unmapped", 32'h0, rd);
    bus(1'b0, fsl_pkg::REG_CFG, 32'h0);
    check("cfg", 32'h0, rd);
  endtask
  task automatic t_status();
    for (int i = 0; i < 8; i++) begin
      fail <= i[1:0];
      bus(1'b1, fsl_pkg::REG_CFG, {31'h0, i[2]});
      op(fsl_pkg::OP_STATUS);
      check("status", {24'h0, i[2], 2'b11, 3'b000, i[1:0]}, {24'h0, rd[15:8]});
      check("wpN", {31'h0, i[2]}, {31'h0, wpN});
    end
  endtask
  task automatic t_poll();
    busy <= 1'b1;
    bus(1'b1, fsl_pkg::REG_CTRL, {29'h0, fsl_pkg::OP_POLL});
    repeat (40) @(posedge clk);
    bus(1'b0, fsl_pkg::REG_STAT, 32'h0);
    check("poll busy", 32'h1, {29'h0, rd[2:0] & 3'h5});
    check("poll busy status", 32'h0, {31'h0, rd[14]});
    busy <= 1'b0;
    idle();
    check("poll ready", 32'h3, {30'h0, rd[14], rd[2]});
  endtask
  task automatic t_sig();
    op(fsl_pkg::OP_SIG);
    bus(1'b0, fsl_pkg::REG_SIG, 32'h0);
    check("signature", {CW, RW, DV, MK}, rd);
    op(fsl_pkg::OP_STATUS);
    check("status after sig", 32'hE3, {24'h0, rd[15:8]});
  endtask
  task automatic t_cache_supply();
    logic [15:0] n;
    cache <= 2'h2;
    op(fsl_pkg::OP_STATUS);
    check("cache busy status", 32'h0, {31'h0, rd[14]});
    check("array ready status", 32'h1, {31'h0, rd[13]});
    cache <= 2'h3;
    op(fsl_pkg::OP_STATUS);
    check("cache ready status", 32'h1, {31'h0, rd[14]});
    cache <= 2'h0;
    supplyLow <= 1'b1;
    n = wrCount;
    op(fsl_pkg::OP_STATUS);
    check("lockout cycles", {16'h0, n}, {16'h0, wrCount});
    supplyLow <= 1'b0;
  endtask
  task automatic t_unlock(input logic [31:0] cfg, input logic [31:0] s, input logic [31:0] e,
      input logic [15:0] cycles);
    logic [15:0] n;
    bus(1'b1, fsl_pkg::REG_CFG, cfg);
    bus(1'b1, fsl_pkg::REG_START, s);
    bus(1'b1, fsl_pkg::REG_END, e);
    n = wrCount;
    busy <= 1'b1;
    bus(1'b1, fsl_pkg::REG_CTRL, {29'h0, fsl_pkg::OP_UNLOCK});
    repeat (30) @(posedge clk);
    check("cycles while busy", {16'h0, n}, {16'h0, wrCount});
    busy <= 1'b0;
    idle();
    check("unlock err", 32'h0, {31'h0, rd[1]});
    check("write cycles", {16'h0, n + cycles}, {16'h0, wrCount});
    check("range start", {8'h0, s[23:0]}, {8'h0, rngStart});
    check("range end", {8'h0, e[23:0]}, {8'h0, rngEnd});
    check("unlocked", 32'h0, {31'h0, lockedAll});
  endtask
  task automatic t_refuse(input logic [31:0] cfg, input logic [2:0] o);
    logic [15:0] n;
    bus(1'b1, fsl_pkg::REG_CFG, cfg);
    n = wrCount;
    op(o);
    check("refused", 32'h1, {31'h0, rd[1]});
    check("no cycles", {16'h0, n}, {16'h0, wrCount});
  endtask
  task automatic t_lock();
    logic [15:0] n;
    bus(1'b1, fsl_pkg::REG_CFG, 32'h3);
    n = wrCount;
    op(fsl_pkg::OP_LOCK);
    check("lock cycles", {16'h0, n + 16'h1}, {16'h0, wrCount});
    check("locked all", 32'h1, {31'h0, lockedAll});
  endtask
  task automatic conclude();
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_status();
    t_poll();
    t_sig();
    t_cache_supply();
    t_unlock(32'h7, 32'h000102, 32'h0A0B0C, 16'h8);
    t_unlock(32'h3, 32'h00FF05, 32'h00FF05, 16'h6);
    t_refuse(32'h1, fsl_pkg::OP_LOCK);
    t_refuse(32'h1, fsl_pkg::OP_UNLOCK);
    bus(1'b1, fsl_pkg::REG_START, 32'hFF06);
    t_refuse(32'h3, fsl_pkg::OP_UNLOCK);
    t_refuse(32'h3, 3'h0);
    t_lock();
    conclude();
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
